// [hw/mas_next_decode.sv]
`timescale 1ns/10ps
`default_nettype none

// turns command and test into an address source and a stack action
module mas_next_decode
   import mas_pkg::*;
(
   input wire logic [2:0] command_i,
   input wire logic test_i,
   output mas_sel_t sel_o,
   output mas_stk_t stk_o
);

   // a low test on a conditional command always falls back to current+1
   always_comb begin
      sel_o = MAS_SEL_STEP1;
      stk_o = MAS_STK_NONE;
      case (command_i)
         CMD_SKIP_ON_TEST: begin
            sel_o = test_i ? MAS_SEL_STEP2 : MAS_SEL_STEP1;
         end
         CMD_STEP_ONE: begin
            sel_o = MAS_SEL_STEP1;
         end
         CMD_LOOP_ON_TEST: begin
            sel_o = test_i ? MAS_SEL_STACK : MAS_SEL_STEP1;
            stk_o = MAS_STK_POP;
         end
         CMD_STACK_RETURN: begin
            sel_o = MAS_SEL_STACK;
            stk_o = MAS_STK_POP;
         end
         CMD_CALL_ON_TEST: begin
            sel_o = test_i ? MAS_SEL_BRANCH : MAS_SEL_STEP1;
            stk_o = test_i ? MAS_STK_PUSH_NEXT : MAS_STK_NONE;
         end
         CMD_MARK_LOOP: begin
            sel_o = MAS_SEL_STEP1;
            stk_o = MAS_STK_PUSH_CUR;
         end
         CMD_JUMP_ON_TEST: begin
            sel_o = test_i ? MAS_SEL_BRANCH : MAS_SEL_STEP1;
         end
         CMD_JUMP_ZERO: begin
            sel_o = MAS_SEL_ZERO;
         end
         default: begin
            sel_o = MAS_SEL_STEP1;
            stk_o = MAS_STK_NONE;
         end
      endcase
   end

endmodule // mas_next_decode

`default_nettype wire

// [hw/mas_pkg.sv]
package mas_pkg;

   // widths of the address path and the return stack
   localparam int ADDR_W = 10;
   localparam int STACK_DEPTH = 4;
   localparam int PTR_W = 2;

   // values after reset
   localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
   localparam logic [PTR_W-1:0] PTR_RST = 2'h0;
   localparam logic OE_RST = 1'b0;

   // increments used by the next-address logic
   localparam logic [ADDR_W-1:0] ADDR_STEP1 = 10'h001;
   localparam logic [ADDR_W-1:0] ADDR_STEP2 = 10'h002;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
   localparam logic [PTR_W-1:0] PTR_STEP = 2'h1;

   // next-address command codes
   localparam logic [2:0] CMD_SKIP_ON_TEST = 3'h0;
   localparam logic [2:0] CMD_STEP_ONE = 3'h1;
   localparam logic [2:0] CMD_LOOP_ON_TEST = 3'h2;
   localparam logic [2:0] CMD_STACK_RETURN = 3'h3;
   localparam logic [2:0] CMD_CALL_ON_TEST = 3'h4;
   localparam logic [2:0] CMD_MARK_LOOP = 3'h5;
   localparam logic [2:0] CMD_JUMP_ON_TEST = 3'h6;
   localparam logic [2:0] CMD_JUMP_ZERO = 3'h7;

   // source of the next address
   typedef enum logic [2:0] {
      MAS_SEL_STEP1,
      MAS_SEL_STEP2,
      MAS_SEL_BRANCH,
      MAS_SEL_STACK,
      MAS_SEL_ZERO
   } mas_sel_t;

   // stack action taken on the falling edge
   typedef enum logic [1:0] {
      MAS_STK_NONE,
      MAS_STK_PUSH_NEXT,
      MAS_STK_PUSH_CUR,
      MAS_STK_POP
   } mas_stk_t;

endpackage

// [hw/mas_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none

module mas_sequencer
   import mas_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [2:0] next_address_command_i,
   input wire logic test_i,
   input wire logic [ADDR_W-1:0] branch_target_in_i,
   input wire logic output_enable_n_i,
   output logic [ADDR_W-1:0] microaddress_out_o,
   output logic microaddress_oe_o
);

   logic [ADDR_W-1:0] addr_r;
   logic [ADDR_W-1:0] addr_nxt;
   logic [PTR_W-1:0] ptr_r;
   logic [PTR_W-1:0] ptr_nxt;
   logic oe_r;
   logic [ADDR_W-1:0] addr_plus1;
   logic [ADDR_W-1:0] addr_plus2;
   logic [ADDR_W-1:0] pop_data;
   logic [ADDR_W-1:0] push_data;
   logic push_en;
   logic pop_en;
   logic [PTR_W-1:0] push_idx;
   mas_sel_t sel;
   mas_stk_t stk;

   // one decoder serves both edges, so the command must hold for the whole cycle
   mas_next_decode u_decode (
      .command_i(next_address_command_i),
      .test_i(test_i),
      .sel_o(sel),
      .stk_o(stk)
   );

   // the +1 and +2 adders wrap inside the 1024-word page
   assign addr_plus1 = addr_r + ADDR_STEP1;
   assign addr_plus2 = addr_r + ADDR_STEP2;

   // five-way next-address selector
   always_comb begin
      addr_nxt = addr_plus1;
      case (sel)
         MAS_SEL_STEP1: begin
            addr_nxt = addr_plus1;
         end
         MAS_SEL_STEP2: begin
            addr_nxt = addr_plus2;
         end
         MAS_SEL_BRANCH: begin
            addr_nxt = branch_target_in_i;
         end
         MAS_SEL_STACK: begin
            addr_nxt = pop_data;
         end
         MAS_SEL_ZERO: begin
            addr_nxt = ADDR_ZERO;
         end
         default: begin
            addr_nxt = addr_plus1;
         end
      endcase
   end

   // address register: only a rising edge changes it, so a held clock repeats the address
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         addr_r <= ADDR_RST;
      end else begin
         addr_r <= addr_nxt;
      end
   end

   // pin enable is registered, so the pins follow the enable one rising edge late
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         oe_r <= OE_RST;
      end else begin
         oe_r <= ~output_enable_n_i;
      end
   end

   assign microaddress_out_o = addr_r;
   assign microaddress_oe_o = oe_r;

   // stack action: a push lands above the pointer, a pop reads at the pointer
   assign push_en = (stk == MAS_STK_PUSH_NEXT) || (stk == MAS_STK_PUSH_CUR);
   assign pop_en = (stk == MAS_STK_POP);
   assign push_idx = ptr_r + PTR_STEP;
   assign push_data = (stk == MAS_STK_PUSH_NEXT) ? addr_plus1 : addr_r;

   // pointer moves modulo four; overflow and underflow are not flagged
   always_comb begin
      ptr_nxt = ptr_r;
      case (stk)
         MAS_STK_PUSH_NEXT: begin
            ptr_nxt = ptr_r + PTR_STEP;
         end
         MAS_STK_PUSH_CUR: begin
            ptr_nxt = ptr_r + PTR_STEP;
         end
         MAS_STK_POP: begin
            ptr_nxt = ptr_r - PTR_STEP;
         end
         MAS_STK_NONE: begin
            ptr_nxt = ptr_r;
         end
         default: begin
            ptr_nxt = ptr_r;
         end
      endcase
   end

   // pointer updates on the falling edge, half a cycle ahead of the address
   always_ff @(negedge clock_i) begin
      if (sys_rst_i) begin
         ptr_r <= PTR_RST;
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   // the popped entry is caught on the falling edge and used at the next rising edge
   mas_stack_mem u_stack (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .wr_en_i(push_en),
      .wr_idx_i(push_idx),
      .wr_data_i(push_data),
      .rd_en_i(pop_en),
      .rd_idx_i(ptr_r),
      .rd_data_o(pop_data)
   );

   // conditional command helpers for the checks below
   logic cond_cmd;
   assign cond_cmd = (next_address_command_i == CMD_SKIP_ON_TEST) ||
                     (next_address_command_i == CMD_LOOP_ON_TEST) ||
                     (next_address_command_i == CMD_CALL_ON_TEST) ||
                     (next_address_command_i == CMD_JUMP_ON_TEST);

   // named steps of the call and loop sequences, and the low pin enable
   sequence s_call_taken;
      (next_address_command_i == CMD_CALL_ON_TEST) && test_i;
   endsequence

   sequence s_mark;
      next_address_command_i == CMD_MARK_LOOP;
   endsequence

   sequence s_return;
      next_address_command_i == CMD_STACK_RETURN;
   endsequence

   sequence s_enable_low;
      !output_enable_n_i;
   endsequence

   sequence s_loop_taken;
      (next_address_command_i == CMD_LOOP_ON_TEST) && test_i;
   endsequence

   // reset keeps the address, the pin enable and the pointer at their start values
   AST_RESET_ADDR_HOLD: assert property (
      @(posedge clock_i)
      sys_rst_i |=> (addr_r == ADDR_RST))
      else $error("address not held at zero during reset");

   AST_RESET_OE_HOLD: assert property (
      @(posedge clock_i)
      sys_rst_i |=> !microaddress_oe_o)
      else $error("pins driven during reset");

   AST_RESET_PTR_HOLD: assert property (
      @(negedge clock_i)
      sys_rst_i |=> (ptr_r == PTR_RST))
      else $error("stack pointer not cleared during reset");

   // pointer movement per command, checked on the falling edge where it happens
   AST_RETURN_PTR: assert property (
      @(negedge clock_i) disable iff (sys_rst_i)
      s_return |=> (ptr_r == $past(ptr_r) - PTR_STEP))
      else $error("return did not decrement the stack pointer");

   AST_CALL_PTR: assert property (
      @(negedge clock_i) disable iff (sys_rst_i)
      s_call_taken |=> (ptr_r == $past(ptr_r) + PTR_STEP))
      else $error("taken call did not increment the stack pointer");

   AST_CALL_HELD_PTR: assert property (
      @(negedge clock_i) disable iff (sys_rst_i)
      ((next_address_command_i == CMD_CALL_ON_TEST) && !test_i) |=> $stable(ptr_r))
      else $error("call with test low moved the stack pointer");

   AST_MARK_PTR: assert property (
      @(negedge clock_i) disable iff (sys_rst_i)
      s_mark |=> (ptr_r == $past(ptr_r) + PTR_STEP))
      else $error("mark_loop did not increment the stack pointer");

   AST_STEP_PTR: assert property (
      @(negedge clock_i) disable iff (sys_rst_i)
      (next_address_command_i == CMD_STEP_ONE) |=> $stable(ptr_r))
      else $error("step_one moved the stack pointer");

   // address results of commands that use the stack
   AST_LOOP_TAKEN: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      s_loop_taken |=> (addr_r == $past(pop_data)))
      else $error("taken loop did not load the popped entry");

   AST_MARK_STEP: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      s_mark |=> (addr_r == $past(addr_r) + ADDR_STEP1))
      else $error("mark_loop did not advance by one");

   AST_MARK_LOOP_BACK: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      s_mark ##1 s_loop_taken |=> (addr_r == $past(addr_r, 2)))
      else $error("taken loop after mark_loop did not reach the marked address");

   // two nested levels unwind in reverse order
   AST_NEST_TWO: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      s_call_taken ##1 s_mark ##1 s_return ##1 s_return
      |=> (addr_r == $past(addr_r, 4) + ADDR_STEP1))
      else $error("nested call and mark did not unwind in order");

   AST_RESET_ZERO: assert property (
      @(posedge clock_i) $fell(sys_rst_i) |-> (addr_r == ADDR_RST) && !microaddress_oe_o)
      else $error("address not zero after reset");

   AST_FALSE_STEP: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (cond_cmd && !test_i) |=> (addr_r == $past(addr_r) + ADDR_STEP1))
      else $error("conditional command with test low did not step by one");

   AST_SKIP_TWO: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      ((next_address_command_i == CMD_SKIP_ON_TEST) && test_i)
      |=> (addr_r == $past(addr_r) + ADDR_STEP2))
      else $error("skip did not advance by two");

   AST_STEP_ONE: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (next_address_command_i == CMD_STEP_ONE) |=> (addr_r == $past(addr_r) + ADDR_STEP1))
      else $error("step_one did not advance by one");

   AST_JUMP_ZERO: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (next_address_command_i == CMD_JUMP_ZERO) |=> (addr_r == ADDR_ZERO))
      else $error("jump_zero did not give address zero");

   AST_BRANCH_TAKEN: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      (((next_address_command_i == CMD_JUMP_ON_TEST) ||
        (next_address_command_i == CMD_CALL_ON_TEST)) && test_i)
      |=> (addr_r == $past(branch_target_in_i)))
      else $error("taken branch did not load the branch input");

   AST_RETURN_TOP: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      s_return |=> (addr_r == $past(pop_data)))
      else $error("return did not load the popped entry");

   AST_CALL_RETURN: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      s_call_taken ##1 s_return |=> (addr_r == $past(addr_r, 2) + ADDR_STEP1))
      else $error("return after call did not resume after the call");

   AST_MARK_RETURN: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      s_mark ##1 s_return |=> (addr_r == $past(addr_r, 2)))
      else $error("return after mark_loop did not reach the marked address");

   AST_PTR_PUSH: assert property (
      @(negedge clock_i) disable iff (sys_rst_i)
      push_en |=> (ptr_r == $past(ptr_r) + PTR_STEP))
      else $error("push did not advance the stack pointer");

   AST_PTR_POP: assert property (
      @(negedge clock_i) disable iff (sys_rst_i)
      (next_address_command_i == CMD_LOOP_ON_TEST) |=> (ptr_r == $past(ptr_r) - PTR_STEP))
      else $error("loop_on_test did not decrement the stack pointer");

   AST_PTR_HOLD: assert property (
      @(negedge clock_i) disable iff (sys_rst_i)
      ((next_address_command_i == CMD_SKIP_ON_TEST) ||
       (next_address_command_i == CMD_JUMP_ON_TEST) ||
       (next_address_command_i == CMD_JUMP_ZERO)) |=> $stable(ptr_r))
      else $error("stack pointer moved on a command that leaves it alone");

   AST_PINS_DRIVEN: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      s_enable_low |=> microaddress_oe_o)
      else $error("pins not driven while enable is low");

   AST_PINS_FLOAT: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      output_enable_n_i [*2] |-> !microaddress_oe_o)
      else $error("pins driven while enable is high");

endmodule // mas_sequencer

`default_nettype wire

// [hw/mas_stack_mem.sv]
`timescale 1ns/10ps
`default_nettype none

// four-entry return stack storage, written and read on the falling edge
module mas_stack_mem
   import mas_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic wr_en_i,
   input wire logic [PTR_W-1:0] wr_idx_i,
   input wire logic [ADDR_W-1:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [PTR_W-1:0] rd_idx_i,
   output logic [ADDR_W-1:0] rd_data_o
);

   logic [ADDR_W-1:0] entry_r [STACK_DEPTH];

   // entries are not cleared; a return before any push gives stale data
   // a command left on the pins while reset is held must not overwrite an entry
   always_ff @(negedge clock_i) begin
      if (wr_en_i && !sys_rst_i) begin
         entry_r[wr_idx_i] <= wr_data_i;
      end
   end

   // read data held in a register until the next pop or reset
   always_ff @(negedge clock_i) begin
      if (sys_rst_i) begin
         rd_data_o <= ADDR_RST;
      end else if (rd_en_i) begin
         rd_data_o <= entry_r[rd_idx_i];
      end
   end

endmodule // mas_stack_mem

`default_nettype wire

// [verif/mas_rom_model.sv]
`timescale 1ns/10ps
`default_nettype none

// control store seen from the address pins; a floating bus gives a word that flips every cycle
module mas_rom_model
   import mas_pkg::*;
(
   input wire logic clock_i,
   input wire logic [ADDR_W-1:0] addr_i,
   output logic [15:0] word_o
);
   logic [15:0] last_r = 16'h5a5a;

   // fixed content: low address bits on top, inverted address below
   always_comb begin
      if ($isunknown(addr_i)) begin
         word_o = ~last_r; // a released bus must not look like the old address
      end else begin
         word_o = {addr_i[5:0], ~addr_i};
      end
   end

   // remember the last word so a floating bus keeps changing
   always_ff @(posedge clock_i) begin
      last_r <= word_o;
   end
endmodule // mas_rom_model

`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_top
   import mas_pkg::*;
;
   logic clock_i, sys_rst_i, test_i, en_n, clk_run, oe_o, exp_oe;
   logic [2:0] cmd;
   logic [ADDR_W-1:0] branch, addr_o;
   logic [15:0] word;
   wire logic [ADDR_W-1:0] addr_bus;
   int miscompares, cmp_count, cur, ptr;
   int stk[4];

   // pins float unless the sequencer drives them
   assign addr_bus = oe_o ? addr_o : {ADDR_W{1'bz}};

   mas_sequencer DUT (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .next_address_command_i(cmd),
      .test_i(test_i),
      .branch_target_in_i(branch),
      .output_enable_n_i(en_n),
      .microaddress_out_o(addr_o),
      .microaddress_oe_o(oe_o)
   );

   mas_rom_model ROM (
      .clock_i(clock_i),
      .addr_i(addr_bus),
      .word_o(word)
   );

   // 4 ns clock that can be held still to freeze the address
   initial begin
      clock_i = 1'b0;
      forever begin
         #2;
         if (clk_run) clock_i = ~clock_i;
      end
   end

   task automatic cmp_addr(input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t addr exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic cmp_bit(input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t oe exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic cmp_word(input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t word exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // entered at a rising edge; model starts over, stack contents kept
   task automatic do_reset;
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      cur = 0;
      ptr = 0;
      exp_oe = 1'b0;
   endtask

   // drive one command, check the previous result mid-cycle, advance the model
   task automatic step(input logic [2:0] c, input logic t, input logic [ADDR_W-1:0] b,
                       input logic e);
      int nxt;
      cmd <= c;
      test_i <= t;
      branch <= b;
      en_n <= e;
      @(negedge clock_i);
      cmp_addr(ADDR_W'(cur), addr_o);
      cmp_bit(exp_oe, oe_o);
      cmp_addr(exp_oe ? ADDR_W'(cur) : {ADDR_W{1'bz}}, addr_bus);
      if (exp_oe) cmp_word({cur[5:0], ~ADDR_W'(cur)}, word);
      nxt = cur + 1;
      case (c)
         CMD_SKIP_ON_TEST: if (t) nxt = cur + 2;
         CMD_LOOP_ON_TEST: begin
            if (t) nxt = stk[ptr];
            ptr = (ptr + 3) % 4;
         end
         CMD_STACK_RETURN: begin
            nxt = stk[ptr];
            ptr = (ptr + 3) % 4;
         end
         CMD_CALL_ON_TEST: if (t) begin
            nxt = b;
            ptr = (ptr + 1) % 4;
            stk[ptr] = (cur + 1) % 1024;
         end
         CMD_MARK_LOOP: begin
            ptr = (ptr + 1) % 4;
            stk[ptr] = cur;
         end
         CMD_JUMP_ON_TEST: if (t) nxt = b;
         CMD_JUMP_ZERO: nxt = 0;
         default: ;
      endcase
      cur = nxt % 1024;
      exp_oe = ~e;
      @(posedge clock_i);
   endtask

   // main sequence: directed corners first, then random traffic across a second reset
   initial begin
      clk_run = 1'b1;
      sys_rst_i = 1'b1;
      cmd = CMD_STEP_ONE;
      test_i = 1'b0;
      branch = 10'h000;
      en_n = 1'b0;
      miscompares = 0;
      cmp_count = 0;
      void'($urandom(69));
      do_reset();
      // fill all four entries so no pop ever sees an unwritten one
      for (int i = 0; i < 4; i++) step(CMD_MARK_LOOP, 1'b0, 10'h155, 1'b0);
      for (int i = 0; i < 16; i++) step(3'(i >> 1), 1'(i), 10'(i * 67), 1'b0);
      // five nested calls overrun the stack, five returns unwind it
      for (int i = 0; i < 5; i++) step(CMD_CALL_ON_TEST, 1'b1, 10'(i * 200 + 3), 1'b0);
      for (int i = 0; i < 5; i++) step(CMD_STACK_RETURN, 1'b0, 10'h000, 1'b0);
      step(CMD_JUMP_ON_TEST, 1'b1, 10'h3ff, 1'b0);
      step(CMD_SKIP_ON_TEST, 1'b1, 10'h000, 1'b0);
      step(CMD_STEP_ONE, 1'b0, 10'h000, 1'b1);
      step(CMD_STEP_ONE, 1'b0, 10'h000, 1'b1);
      step(CMD_STEP_ONE, 1'b1, 10'h000, 1'b0);
      // hold the clock high; odd delay keeps the restart off the toggle instant
      clk_run = 1'b0;
      #41;
      cmp_addr(ADDR_W'(cur), addr_o);
      clk_run = 1'b1;
      repeat (2000) step(3'($urandom), 1'($urandom), 10'($urandom), 1'($urandom % 4 == 0));
      do_reset();
      repeat (200) step(3'($urandom), 1'($urandom), 10'($urandom), 1'($urandom % 4 == 0));
      step(CMD_STEP_ONE, 1'b0, 10'h000, 1'b0);
      give_verdict();
   end

   // watchdog well beyond the roughly 2300 cycles the sequence needs
   initial begin
      #(20000 * 4);
      miscompares++;
      give_verdict();
   end
endmodule // tb_top

`default_nettype wire
